// *** src/wts_defines.svh ***
// Register offsets, field positions and constants of the wavetable register port.
`ifndef WTS_DEFINES_SVH
`define WTS_DEFINES_SVH
`define WTS_OFS_OUT_HI 8'h1d
`define WTS_OFS_OUT_LO 8'h1e
`define WTS_OFS_CTRL 8'h1f
`define WTS_OFS_VSEL 8'h20
`define WTS_OFS_PITCH_HI 8'h21
`define WTS_OFS_PITCH_LO 8'h22
`define WTS_OFS_ORG_HI 8'h23
`define WTS_OFS_ORG_LO 8'h24
`define WTS_OFS_FMT 8'h25
`define WTS_OFS_LOOP_LO 8'h26
`define WTS_OFS_ATT_HI 8'h27
`define WTS_OFS_ATT_LO 8'h2a
`define WTS_CTRL_ON_BIT 1
`define WTS_CTRL_FEED_BIT 0
`define WTS_VSEL_VOL_BIT 7
`define WTS_VSEL_PITCH_BIT 6
`define WTS_FMT_WIDTH_BIT 7
`define WTS_END_MARKER 8'h80
`define WTS_ORIGIN_SHIFT 5
`define WTS_ATT_MAX 10'h3ff
`define WTS_PHASE_UNITY_SHIFT 17
`define WTS_SAMPLE_PERIOD 8000
`endif

// *** src/wts_pkg.sv ***
// Types shared by the wavetable register port.
package wts_pkg;
  typedef struct packed {
    logic [3:0] octave_shift;
    logic [11:0] pitch_number;
    logic [10:0] origin_index;
    logic sample_width_sel;
    logic [9:0] loop_length_code;
    logic [9:0] attenuation_level;
  } wts_voice_t;

  typedef struct packed {
    logic [2:0] voice;
    logic [15:0] addr;
  } wts_fetch_t;

  typedef enum logic [1:0] {
    WTS_IDLE = 2'b00,
    WTS_FETCH = 2'b01,
    WTS_WAIT = 2'b10,
    WTS_EMIT = 2'b11
  } wts_mix_state_t;
endpackage : wts_pkg

// *** src/wts_fifo.sv ***
// Parameterised FIFO carrying mixed output words to the converter side.
module wts_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("wts_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic full;
  logic empty;
  assign empty = (wr_r == rd_r);
  assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wr_r <= '0;
    else if (in_valid && !full)
      wr_r <= wr_r + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (in_valid && !full)
      mem_r[wr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rd_r <= '0;
    else if (out_ready && !empty)
      rd_r <= rd_r + 1'b1;
  end
endmodule : wts_fifo

// *** src/wts_synth.sv ***
// Register port, voice contexts, sample fetch, mixer and converter feed of the wavetable synthesizer.
`include "wts_defines.svh"

module wts_synth #(
  parameter int VOICES = 8,
  parameter int SAMPLE_PERIOD = `WTS_SAMPLE_PERIOD,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Processor data-memory port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sample memory port
  output logic [15:0] pattern_memory_index,
  output logic rom_req,
  input wire logic rom_ack,
  input wire logic [7:0] rom_data,
  // Converter
  output logic converter_on,
  output logic [15:0] dac_word
);
  initial
  begin
    if (VOICES != 8) $error("wts_synth serves exactly eight voices");
    if (SAMPLE_PERIOD < 4 * VOICES) $error("wts_synth sample period too short for the voice scan");
  end

  function automatic logic [15:0] origin_addr(input logic [10:0] org);
    origin_addr = {org, 5'h00} << 0;
  endfunction : origin_addr

  function automatic logic [15:0] loop_addr(input logic [15:0] end_at, input logic [9:0] code);
    loop_addr = end_at + {{6{code[9]}}, code};
  endfunction : loop_addr

  // Staging registers and control.
  logic [15:0] output_word_r;
  logic [7:0] ctrl_r;
  logic [7:0] vsel_r;
  wts_pkg::wts_voice_t stage_r;
  wts_pkg::wts_voice_t ctx_r [8];
  logic [7:0] active_r;
  logic [15:0] addr_r [8];
  logic [27:0] phase_r [8];
  logic [7:0] sample_r [8];
  logic trig;
  logic [2:0] trig_voice;

  assign trig = reg_wr && (reg_addr == `WTS_OFS_VSEL);
  assign trig_voice = reg_wdata[2:0];

  always_ff @(posedge mclk)
  begin
    if (reg_wr && reg_addr == `WTS_OFS_OUT_HI)
      output_word_r[15:8] <= reg_wdata;
    if (reg_wr && reg_addr == `WTS_OFS_OUT_LO)
      output_word_r[7:0] <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ctrl_r <= 8'h00;
    else if (reg_wr && reg_addr == `WTS_OFS_CTRL)
      ctrl_r <= {6'h00, reg_wdata[1:0]};
  end

  // Parameter staging is kept across reset, as the parameter registers are.
  always_ff @(posedge mclk)
  begin
    if (reg_wr)
    begin
      case (reg_addr)
        `WTS_OFS_VSEL: vsel_r <= {reg_wdata[7:6], 3'h0, reg_wdata[2:0]};
        `WTS_OFS_PITCH_HI: {stage_r.octave_shift, stage_r.pitch_number[11:8]} <= reg_wdata;
        `WTS_OFS_PITCH_LO: stage_r.pitch_number[7:0] <= reg_wdata;
        `WTS_OFS_ORG_HI: stage_r.origin_index[10:8] <= reg_wdata[2:0];
        `WTS_OFS_ORG_LO: stage_r.origin_index[7:0] <= reg_wdata;
        `WTS_OFS_FMT:
        begin
          stage_r.sample_width_sel <= reg_wdata[`WTS_FMT_WIDTH_BIT];
          stage_r.loop_length_code[9:8] <= reg_wdata[1:0];
        end
        `WTS_OFS_LOOP_LO: stage_r.loop_length_code[7:0] <= reg_wdata;
        `WTS_OFS_ATT_HI: stage_r.attenuation_level[9:8] <= reg_wdata[1:0];
        `WTS_OFS_ATT_LO: stage_r.attenuation_level[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Trigger copy into the voice context; software must have staged everything first.
  always_ff @(posedge mclk)
  begin
    if (trig)
    begin
      case (reg_wdata[`WTS_VSEL_VOL_BIT:`WTS_VSEL_PITCH_BIT])
        2'b01:
        begin
          ctx_r[trig_voice].octave_shift <= stage_r.octave_shift;
          ctx_r[trig_voice].pitch_number <= stage_r.pitch_number;
        end
        2'b10: ctx_r[trig_voice].attenuation_level <= stage_r.attenuation_level;
        2'b00: ctx_r[trig_voice] <= stage_r;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_addr)
      `WTS_OFS_OUT_HI: reg_rdata = output_word_r[15:8];
      `WTS_OFS_OUT_LO: reg_rdata = output_word_r[7:0];
      `WTS_OFS_CTRL: reg_rdata = ctrl_r;
      `WTS_OFS_VSEL: reg_rdata = vsel_r;
      `WTS_OFS_PITCH_HI: reg_rdata = {stage_r.octave_shift, stage_r.pitch_number[11:8]};
      `WTS_OFS_PITCH_LO: reg_rdata = stage_r.pitch_number[7:0];
      `WTS_OFS_ORG_HI: reg_rdata = {5'h00, stage_r.origin_index[10:8]};
      `WTS_OFS_ORG_LO: reg_rdata = stage_r.origin_index[7:0];
      `WTS_OFS_FMT: reg_rdata = {stage_r.sample_width_sel, 5'h00, stage_r.loop_length_code[9:8]};
      `WTS_OFS_LOOP_LO: reg_rdata = stage_r.loop_length_code[7:0];
      `WTS_OFS_ATT_HI: reg_rdata = {6'h00, stage_r.attenuation_level[9:8]};
      `WTS_OFS_ATT_LO: reg_rdata = stage_r.attenuation_level[7:0];
      default: reg_rdata = 8'h00;
    endcase
  end

  // Sample scan: once per sample period every active voice fetches one byte.
  wts_pkg::wts_mix_state_t state_r;
  logic [$clog2(SAMPLE_PERIOD)-1:0] tick_r;
  logic [2:0] scan_r;
  logic [23:0] acc_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic tick_hit;
  logic fetch_end;
  logic [10:0] gain;
  logic [7:0] cur;

  assign tick_hit = (tick_r == '0);
  assign fetch_end = rom_ack && (rom_data == `WTS_END_MARKER);
  assign cur = sample_r[scan_r];
  assign gain = 11'h400 - {1'b0, ctx_r[scan_r].attenuation_level};

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tick_r <= '0;
    else if (tick_hit)
      tick_r <= $bits(tick_r)'(SAMPLE_PERIOD - 1);
    else
      tick_r <= tick_r - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= wts_pkg::WTS_IDLE;
      scan_r <= 3'h0;
      acc_r <= 24'h000000;
    end
    else
    begin
      case (state_r)
        wts_pkg::WTS_IDLE:
          if (tick_hit && fifo_in_ready)
          begin
            state_r <= wts_pkg::WTS_FETCH;
            scan_r <= 3'h0;
            acc_r <= 24'h000000;
          end
        wts_pkg::WTS_FETCH:
          state_r <= active_r[scan_r] ? wts_pkg::WTS_WAIT : wts_pkg::WTS_EMIT;
        wts_pkg::WTS_WAIT:
          if (rom_ack)
            state_r <= wts_pkg::WTS_EMIT;
        wts_pkg::WTS_EMIT:
        begin
          if (active_r[scan_r])
            acc_r <= acc_r + (signed'({{16{cur[7]}}, cur}) * signed'({13'h0000, gain}));
          if (scan_r == 3'h7)
            state_r <= wts_pkg::WTS_IDLE;
          else
            state_r <= wts_pkg::WTS_FETCH;
          scan_r <= scan_r + 3'h1;
        end
        default: state_r <= wts_pkg::WTS_IDLE;
      endcase
    end
  end

  assign rom_req = (state_r == wts_pkg::WTS_WAIT);
  assign pattern_memory_index = addr_r[scan_r];

  // Voice address walk; a play trigger (select bits 7:6 clear) restarts the voice at its origin.
  genvar v;
  generate
    for (v = 0; v < 8; v++)
    begin : g_voice
      logic hit;
      assign hit = (state_r == wts_pkg::WTS_WAIT) && rom_ack && (scan_r == 3'(v));
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          active_r[v] <= 1'b0;
        else if (trig && trig_voice == 3'(v) && !reg_wdata[`WTS_VSEL_VOL_BIT] && !reg_wdata[`WTS_VSEL_PITCH_BIT])
          active_r[v] <= 1'b1;
        else if (hit && ctx_r[v].attenuation_level == `WTS_ATT_MAX)
          active_r[v] <= 1'b0;
      end
      always_ff @(posedge mclk)
      begin
        if (trig && trig_voice == 3'(v) && reg_wdata[7:6] == 2'b00)
        begin
          addr_r[v] <= origin_addr(stage_r.origin_index);
          phase_r[v] <= 28'h0;
          sample_r[v] <= 8'h00;
        end
        else if (hit)
        begin
          if (fetch_end)
            addr_r[v] <= loop_addr(addr_r[v], ctx_r[v].loop_length_code);
          else
          begin
            sample_r[v] <= rom_data;
            phase_r[v] <= phase_r[v] + ({16'h0, ctx_r[v].pitch_number} << ctx_r[v].octave_shift);
            // The step is taken at the phase's own integer width, so a phase wrap cannot throw the address.
            addr_r[v] <= addr_r[v] + {5'h00, 11'(
              (phase_r[v] + ({16'h0, ctx_r[v].pitch_number} << ctx_r[v].octave_shift)) >> `WTS_PHASE_UNITY_SHIFT)
              - 11'(phase_r[v] >> `WTS_PHASE_UNITY_SHIFT)};
          end
        end
      end
    end
  endgenerate

  // The last voice reaches the accumulator on the edge that ends the scan, so the push waits one cycle.
  logic push_r;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      push_r <= 1'b0;
    else
      push_r <= (state_r == wts_pkg::WTS_EMIT) && (scan_r == 3'h7);
  end

  wts_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(acc_r[23:8]),
    .out_valid(fifo_out_valid),
    .out_ready(tick_hit),
    .out_data(fifo_out_data)
  );

  // The converter takes one mixed word per sample period, so the FIFO only absorbs scan jitter.
  logic [15:0] mix_word_r;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mix_word_r <= 16'h0000;
    else if (tick_hit && fifo_out_valid)
      mix_word_r <= fifo_out_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      dac_word <= 16'h0000;
    else if (!ctrl_r[`WTS_CTRL_ON_BIT])
      dac_word <= 16'h0000;
    else
      dac_word <= ctrl_r[`WTS_CTRL_FEED_BIT] ? mix_word_r : output_word_r;
  end

  assign converter_on = ctrl_r[`WTS_CTRL_ON_BIT];
endmodule : wts_synth

// *** tb/wts_synth_sva.sv ***
// Port-level concurrent checks of the wavetable register port.
`include "wts_defines.svh"
module wts_synth_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Processor port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Sample memory and converter
  input wire logic [15:0] pattern_memory_index,
  input wire logic rom_req,
  input wire logic rom_ack,
  input wire logic converter_on,
  input wire logic [15:0] dac_word
);
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] word_r;
  logic feed_r;
  logic trig_r;
  always_ff @(posedge mclk)
  begin
    if (reg_wr && reg_addr == `WTS_OFS_OUT_HI) word_r[15:8] <= reg_wdata;
    if (reg_wr && reg_addr == `WTS_OFS_OUT_LO) word_r[7:0] <= reg_wdata;
  end
  always_ff @(posedge mclk)
  begin
    if (reg_wr && reg_addr == `WTS_OFS_CTRL) feed_r <= reg_wdata[0];
  end
  // Nothing may fetch before the first trigger write since reset.
  always_ff @(posedge mclk)
  begin
    if (!rst_n) trig_r <= 1'b0;
    else if (reg_wr && reg_addr == `WTS_OFS_VSEL) trig_r <= 1'b1;
  end
  a_conv_on_follow: assert property (reg_wr && reg_addr == `WTS_OFS_CTRL |=> converter_on == $past(reg_wdata[1]))
    else $error("converter power does not follow control write");
  a_dac_off_zero: assert property (!converter_on [*2] |-> dac_word == 16'h0000)
    else $error("converter word not zero while off");
  a_proc_word_feed: assert property ((converter_on && !feed_r && !reg_wr) [*2] |-> dac_word == word_r)
    else $error("converter word differs from processor word");
  a_pitch_read_back: assert property (reg_wr && reg_addr == `WTS_OFS_PITCH_LO ##1 reg_addr == `WTS_OFS_PITCH_LO
    |-> reg_rdata == $past(reg_wdata))
    else $error("pitch low byte not read back");
  a_vsel_reserved: assert property (reg_addr == `WTS_OFS_VSEL |-> reg_rdata[5:3] == 3'h0)
    else $error("voice select reserved bits not zero");
  a_origin_reserved: assert property (reg_addr == `WTS_OFS_ORG_HI |-> reg_rdata[7:3] == 5'h00)
    else $error("origin high reserved bits not zero");
  a_att_reserved: assert property (reg_addr == `WTS_OFS_ATT_HI |-> reg_rdata[7:2] == 6'h00)
    else $error("attenuation high reserved bits not zero");
  a_req_hold: assert property (rom_req && !rom_ack |=> rom_req && $stable(pattern_memory_index))
    else $error("fetch request or index dropped before answer");
  a_trig_fetch: assert property (reg_wr && reg_addr == `WTS_OFS_VSEL && reg_wdata[7:6] == 2'b00
    |-> ##[1:300] rom_req)
    else $error("no fetch after play trigger");
  a_quiet_start: assert property (!trig_r |-> !rom_req)
    else $error("fetch without any trigger");
endmodule : wts_synth_sva

bind wts_synth wts_synth_sva i_wts_synth_sva (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pattern_memory_index(pattern_memory_index),
  .rom_req(rom_req), .rom_ack(rom_ack), .converter_on(converter_on), .dac_word(dac_word));

// *** tb/wts_rom_model.sv ***
// Behavioural sample memory answering the fetch handshake, promptly or slowly.
`include "wts_defines.svh"
module wts_rom_model (
  // Clock
  input wire logic mclk,
  // Fetch handshake
  input wire logic rom_req,
  input wire logic [15:0] addr,
  output logic rom_ack,
  output logic [7:0] rom_data,
  // Answer speed
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  initial
  begin
    rom_ack = 1'b0;
    rom_data = 8'h00;
  end
  // Outside an answer the data toggles, so a design sampling it early sees garbage.
  always @(posedge mclk)
  begin
    rom_ack <= 1'b0;
    rom_data <= ~rom_data;
    if (rom_req && !rom_ack)
    begin
      if (wait_cnt >= (slow ? 4 : 0))
      begin
        rom_ack <= 1'b1;
        rom_data <= (addr[4:0] == 5'h1f) ? `WTS_END_MARKER : {3'h0, addr[4:0]};
        wait_cnt <= 0;
      end
      else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : wts_rom_model

// *** tb/wts_synth_tb.sv ***
// Register-level testbench of the wavetable register port.
`include "wts_defines.svh"
module wts_synth_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [15:0] pattern_memory_index;
  logic rom_req;
  logic rom_ack;
  logic [7:0] rom_data;
  logic converter_on;
  logic [15:0] dac_word;
  logic slow = 1'b0;
  logic [15:0] seen;
  logic [7:0] dat;
  int error_cnt = 0;
  int checks = 0;
  int idx;
  logic [7:0] ofs [12] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2a};
  logic [7:0] msk [12] = '{8'hff, 8'hff, 8'h03, 8'hc7, 8'hff, 8'hff, 8'h07, 8'hff, 8'h83, 8'hff, 8'h03, 8'hff};
  // Voice 3: unity pitch, origin 123h, loop back 16, loudest; voice select written last.
  logic [15:0] prog [9] = '{16'h2168, 16'h2200, 16'h2301, 16'h2423, 16'h2503, 16'h26f0, 16'h2700, 16'h2a00, 16'h2003};
  always #2.5 mclk = ~mclk;
  wts_synth #(.SAMPLE_PERIOD(64)) i_wts_synth (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pattern_memory_index(pattern_memory_index), .rom_req(rom_req),
    .rom_ack(rom_ack), .rom_data(rom_data), .converter_on(converter_on), .dac_word(dac_word));
  wts_rom_model i_wts_rom_model (.mclk(mclk), .rom_req(rom_req), .addr(pattern_memory_index), .rom_ack(rom_ack),
    .rom_data(rom_data), .slow(slow));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    #1;
    chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd_chk
  task automatic next_fetch(output logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (!(rom_req && rom_ack) && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    a = pattern_memory_index;
    d = rom_data;
    chk("fetch wait", 16'h0000, {15'h0000, n >= 1000});
  endtask : next_fetch
  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    for (idx = 0; idx < 12; idx++)
    begin
      wr(ofs[idx], 8'hff);
      rd_chk(ofs[idx], msk[idx]);
    end
    wr(8'h28, 8'hff);
    rd_chk(8'h28, 8'h00);
    wr(`WTS_OFS_CTRL, 8'h00);
    repeat (2) @(negedge mclk);
    chk("dac_word", 16'h0000, dac_word);
    wr(`WTS_OFS_OUT_HI, 8'h12);
    wr(`WTS_OFS_OUT_LO, 8'h34);
    wr(`WTS_OFS_CTRL, 8'h02);
    @(negedge mclk);
    chk("converter_on", 16'h0001, {15'h0000, converter_on});
    chk("dac_word", 16'h1234, dac_word);
    slow = 1'b1;
    for (idx = 0; idx < 9; idx++) wr(prog[idx][15:8], prog[idx][7:0]);
    next_fetch(seen, dat);
    chk("start index", 16'h2460, seen);
    repeat (31) next_fetch(seen, dat);
    chk("marker index", 16'h247f, seen);
    next_fetch(seen, dat);
    chk("loop index", 16'h246f, seen);
    // A lone voice at full volume lands in the mix one sample period after its fetch.
    wr(`WTS_OFS_CTRL, 8'h03);
    repeat (62) @(negedge mclk);
    chk("mix word", {6'h00, dat, 2'b00}, dac_word);
    wr(`WTS_OFS_ATT_HI, 8'h03);
    wr(`WTS_OFS_ATT_LO, 8'hff);
    wr(`WTS_OFS_VSEL, 8'h83);
    repeat (200) @(negedge mclk);
    idx = 0;
    repeat (200)
    begin
      @(negedge mclk);
      idx += rom_req;
    end
    chk("fetches after fade", 16'h0000, idx[15:0]);
    give_verdict();
  end
  // The tests need about 2700 cycles; this leaves a wide margin.
  initial
  begin
    #100us;
    chk("watchdog", 16'h0000, 16'h0001);
    give_verdict();
  end
endmodule : wts_synth_tb
